// *** hdl/seg_status_pkg.sv ***
package seg_status_pkg;
   // register word indices on the plain port
   localparam logic [3:0] OFS_SEG_CMD = 4'h0;
   localparam logic [3:0] OFS_SEG_STATE = 4'h1;
   localparam logic [3:0] OFS_CONFIG = 4'h2;
   localparam logic [3:0] OFS_LAMP_STATE = 4'h3;
   localparam logic [3:0] OFS_LAMP_ERR = 4'h4;
   localparam logic [3:0] OFS_MOD_ERR = 4'h5;
   localparam logic [3:0] OFS_SENSOR = 4'h6;
   localparam logic [3:0] OFS_SB_CMD = 4'h7;
   localparam logic [3:0] OFS_SB_STATUS = 4'h8;
   // config field positions
   localparam int CFG_POLICY_LSB = 0;
   localparam int CFG_COMBINE_BIT = 2;
   localparam int CFG_PRESENT_LSB = 3;
   localparam int CFG_PCT_LSB = 7;
   // feedback policies
   localparam logic [1:0] POL_TRUE = 2'h0;
   localparam logic [1:0] POL_PCT = 2'h1;
   localparam logic [1:0] POL_FIRST = 2'h2;
   // reset values: true feedback, separate errors, all four sensors, 50 percent
   localparam logic [15:0] CFG_RESET = 16'h1978;
   localparam logic [1:0] SEG_CMD_RESET = 2'h0;
   // stopbar command and status bits
   localparam int SBCMD_TOGGLE_BIT = 8;
   localparam int ST_IDLE_BIT = 8;
   localparam int ST_PRES_BIT = 9;
   localparam int ST_EXIT_BIT = 10;
   localparam int ST_INC_BIT = 11;
   // timing
   localparam longint CLK_HZ = 100000000;
   localparam longint TICK_S = 1;
   localparam int TICK_CYCLES = int'(CLK_HZ * TICK_S);
   localparam logic [4:0] WINDOW_S = 5'd30;
   localparam logic [4:0] FALLBACK_S = 5'd10;
   // presence detector states
   typedef enum logic [1:0] {
      DET_IDLE = 2'b00,
      DET_PRES = 2'b01,
      DET_EXIT = 2'b10
   } det_e;
endpackage : seg_status_pkg

// *** hdl/seg_status.sv ***
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ns
// How it works
// RULE_01: each segment command bit is host written and read back; 1 on, 0 off
// RULE_02: true feedback: state follows command once all healthy modules report it
// RULE_03: percentage policy: state follows once configured share of healthy modules agree
// RULE_04: first-module policy: state follows once any healthy module agrees
// RULE_05: circuit power off forces segment and lamp states of that circuit off
// RULE_06: sensor state 1 is detect; forced to no detect while power off
// RULE_07: sensor error 1 is failure; frozen while circuit power is off
// RULE_08: lamp and module errors reported separately unless combine is configured
// RULE_09: power loss clears lamp state except modules with error or lamp fault
// RULE_10: lamp error 1 is failure; held through circuit power loss
// RULE_11: module error 1 is failure; held through circuit power loss
// RULE_12: host switches lamps only through segment commands, never per module
// RULE_13: up to four sensors, any subset marked present in config
// RULE_14: stopbar sensor relights, clears first lead segment, feeds incursion; else timer one
// RULE_15: third and fourth sensors clear second and third lead; absent ones use timers
// RULE_16: detector has idle, exit and presence states; idle when nothing tracked
// RULE_17: stopbar detect in idle gives exit; presence detect returns idle, 30 s tolerance
// RULE_18: presence detect in idle gives presence; stopbar detect returns idle, 30 s tolerance
// RULE_19: stopbar detect ending presence with stopbar lit sets incursion for 30 s
// RULE_20: toggle-presence command forces presence set or cleared
// RULE_21: stopbar commands act on 0-to-1 transitions; host clears the word
// RULE_22: incursion in status bit 11, raised only while stopbar macro is on
// RULE_23: windows counted by one-second tick from core clock; reset gives idle
module seg_status #(
   parameter int TICK_CYCLES = seg_status_pkg::TICK_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic [1:0] circ_pwr_off,
   input wire logic [15:0] mod_lamp_on,
   input wire logic [15:0] mod_lamp_fault,
   input wire logic [15:0] mod_fail,
   input wire logic [3:0] sensor_detect,
   input wire logic [3:0] sensor_fail,
   input wire logic stopbar_on,
   output logic [1:0] seg_cmd,
   output logic relight,
   output logic [2:0] lead_off,
   output logic incursion
);
   import seg_status_pkg::*;

   // =====================================================================
   // helpers
   function automatic logic [3:0] popcount8(input logic [7:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++)
         n = n + {3'h0, v[i]};
      return n;
   endfunction : popcount8

   // =====================================================================
   // register file
   logic [1:0] seg_cmd_q;
   logic [1:0] seg_state_q;
   logic [15:0] cfg_q;
   logic [15:0] lamp_state_q;
   logic [15:0] lamp_err_q;
   logic [15:0] mod_err_q;
   logic [3:0] sens_state_q;
   logic [3:0] sens_err_q;
   logic [15:0] sb_cmd_q;
   logic [15:0] sb_cmd_prev_q;
   logic [15:0] rdata_q;
   det_e det_q;
   det_e det_d;
   logic inc_q;

   wire wr_seg_cmd = reg_wr && reg_addr == OFS_SEG_CMD;
   wire wr_cfg = reg_wr && reg_addr == OFS_CONFIG;
   wire wr_sb_cmd = reg_wr && reg_addr == OFS_SB_CMD;
   wire [1:0] policy = cfg_q[CFG_POLICY_LSB +: 2];
   wire combine = cfg_q[CFG_COMBINE_BIT];
   wire [3:0] present = cfg_q[CFG_PRESENT_LSB +: 4]; // RULE_13
   wire [6:0] pct = cfg_q[CFG_PCT_LSB +: 7];
   // combined mode folds module failures into the lamp error word
   wire [15:0] lamp_err_rd = combine ? (lamp_err_q | mod_err_q) : lamp_err_q; // RULE_08
   wire [15:0] mod_err_rd = combine ? 16'h0000 : mod_err_q; // RULE_08
   wire [15:0] sb_status = {4'h0, inc_q, det_q == DET_EXIT, det_q == DET_PRES,
                            det_q == DET_IDLE, 8'h00};
   logic [15:0] rd_mux;
   always_comb
   begin
      case (reg_addr)
         OFS_SEG_CMD: rd_mux = {14'h0000, seg_cmd_q}; // RULE_01
         OFS_SEG_STATE: rd_mux = {14'h0000, seg_state_q};
         OFS_CONFIG: rd_mux = cfg_q;
         OFS_LAMP_STATE: rd_mux = lamp_state_q;
         OFS_LAMP_ERR: rd_mux = lamp_err_rd;
         OFS_MOD_ERR: rd_mux = mod_err_rd;
         OFS_SENSOR: rd_mux = {8'h00, sens_err_q, sens_state_q};
         OFS_SB_CMD: rd_mux = sb_cmd_q;
         OFS_SB_STATUS: rd_mux = sb_status; // RULE_22
         default: rd_mux = 16'h0000;
      endcase
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge core_clk)
      rdata_q <= (rst_n && reg_rd) ? rd_mux : 16'h0000;

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         seg_cmd_q <= SEG_CMD_RESET;
         cfg_q <= CFG_RESET;
         sb_cmd_q <= 16'h0000;
         sb_cmd_prev_q <= 16'h0000;
      end
      else
      begin
         if (wr_seg_cmd)
            seg_cmd_q <= reg_wdata[1:0]; // RULE_01
         if (wr_cfg)
            cfg_q <= reg_wdata;
         if (wr_sb_cmd)
            sb_cmd_q <= reg_wdata & 16'h0100; // unused bits read as zero
         sb_cmd_prev_q <= sb_cmd_q;
      end
   end

   // edge of the command bit, so a word left set is not reissued
   wire toggle_cmd = sb_cmd_q[SBCMD_TOGGLE_BIT] && !sb_cmd_prev_q[SBCMD_TOGGLE_BIT]; // RULE_21

   // =====================================================================
   // lamp, module and sensor status
   // module 8s..8s+7 belongs to segment s on circuit s; sensors sit on circuit 0
   wire [15:0] pwr_mask = {{8{circ_pwr_off[1]}}, {8{circ_pwr_off[0]}}};
   wire [15:0] faulty = lamp_err_q | mod_err_q;
   // held bits only refresh while their circuit is powered
   wire [15:0] lamp_err_d = (pwr_mask & lamp_err_q) | (~pwr_mask & mod_lamp_fault); // RULE_10
   wire [15:0] mod_err_d = (pwr_mask & mod_err_q) | (~pwr_mask & mod_fail); // RULE_11
   wire [15:0] lamp_state_d = (pwr_mask & faulty & lamp_state_q)
                              | (~pwr_mask & mod_lamp_on); // RULE_05 RULE_09
   wire [3:0] sens_state_d = circ_pwr_off[0] ? 4'h0 : sensor_detect; // RULE_06
   wire [3:0] sens_err_d = circ_pwr_off[0] ? sens_err_q : sensor_fail; // RULE_07

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         lamp_state_q <= 16'h0000;
         lamp_err_q <= 16'h0000;
         mod_err_q <= 16'h0000;
         sens_state_q <= 4'h0;
         sens_err_q <= 4'h0;
      end
      else
      begin
         lamp_state_q <= lamp_state_d;
         lamp_err_q <= lamp_err_d;
         mod_err_q <= mod_err_d;
         sens_state_q <= sens_state_d;
         sens_err_q <= sens_err_d;
      end
   end

   // =====================================================================
   // segment state feedback
   logic [1:0] seg_hit;
   always_comb
   begin
      logic [7:0] good;
      logic [7:0] agree;
      logic [3:0] n_good;
      logic [3:0] n_agree;
      good = 8'h00;
      agree = 8'h00;
      n_good = 4'h0;
      n_agree = 4'h0;
      seg_hit = 2'b00;
      for (int s = 0; s < 2; s++)
      begin
         good = ~faulty[8*s +: 8];
         agree = good & ~(mod_lamp_on[8*s +: 8] ^ {8{seg_cmd_q[s]}});
         n_good = popcount8(good);
         n_agree = popcount8(agree);
         case (policy)
            POL_TRUE: seg_hit[s] = n_agree == n_good; // RULE_02
            POL_PCT: seg_hit[s] = 11'(n_agree * 7'd100) >= 11'(n_good * pct); // RULE_03
            POL_FIRST: seg_hit[s] = n_agree != 4'h0; // RULE_04
            default: seg_hit[s] = n_agree == n_good;
         endcase
      end
   end

   // power loss forces off, else the state takes the command once the policy is met
   wire [1:0] seg_state_d = ~circ_pwr_off
                            & ((seg_hit & seg_cmd_q) | (~seg_hit & seg_state_q)); // RULE_05
   always_ff @(posedge core_clk)
      seg_state_q <= rst_n ? seg_state_d : 2'b00;

   // =====================================================================
   // one-second tick
   // full-width counter; a short TICK_CYCLES speeds simulation
   logic [31:0] tick_cnt_q;
   logic tick_q;
   always_ff @(posedge core_clk)
   begin
      if (!rst_n || tick_cnt_q == 32'(TICK_CYCLES - 1))
         tick_cnt_q <= 32'h0000_0000;
      else
         tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
   end
   always_ff @(posedge core_clk)
      tick_q <= rst_n && tick_cnt_q == 32'(TICK_CYCLES - 1); // RULE_23

   // =====================================================================
   // sensor edges and fallback timers
   logic [3:0] sens_prev_q;
   logic sb_on_prev_q;
   logic [4:0] fb_cnt_q [3];
   wire [3:0] sens_rise = sens_state_q & ~sens_prev_q;
   wire sb_falls = sb_on_prev_q && !stopbar_on;
   wire sb_rises = stopbar_on && !sb_on_prev_q;
   // a stage advances from its sensor if fitted, else from its own timer
   wire [2:0] fb_fire = {3{tick_q}}
                        & {fb_cnt_q[2] == 5'd1, fb_cnt_q[1] == 5'd1, fb_cnt_q[0] == 5'd1};
   wire [2:0] stage_ev = (present[3:1] & sens_rise[3:1])
                         | (~present[3:1] & fb_fire); // RULE_14 RULE_15
   wire pres_ev = present[0] && sens_rise[0];

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         sens_prev_q <= 4'h0;
         sb_on_prev_q <= 1'b0;
         for (int k = 0; k < 3; k++)
            fb_cnt_q[k] <= 5'd0;
      end
      else
      begin
         sens_prev_q <= sens_state_q;
         sb_on_prev_q <= stopbar_on;
         // timer one starts at clearance, each later timer at the stage before it
         for (int k = 0; k < 3; k++)
         begin
            if ((k == 0) ? sb_falls : stage_ev[k == 0 ? 0 : k-1])
               fb_cnt_q[k] <= FALLBACK_S;
            else if (tick_q && fb_cnt_q[k] != 5'd0)
               fb_cnt_q[k] <= fb_cnt_q[k] - 5'd1;
         end
      end
   end

   // relight pulse and lead-on switch-off, cleared when the stopbar relights
   logic relight_q;
   logic [2:0] lead_off_q;
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         relight_q <= 1'b0;
         lead_off_q <= 3'b000;
      end
      else
      begin
         relight_q <= stage_ev[0]; // RULE_14
         lead_off_q <= sb_rises ? stage_ev : (lead_off_q | stage_ev); // RULE_15
      end
   end

   // =====================================================================
   // presence detector
   logic [4:0] tol_cnt_q;
   logic tol_sb_q;
   logic [4:0] inc_cnt_q;
   wire sb_ev = stage_ev[0];
   wire tol_on = tol_cnt_q != 5'd0;
   wire inc_set = det_q == DET_PRES && !toggle_cmd && sb_ev && stopbar_on; // RULE_19 RULE_22
   always_comb
   begin
      det_d = det_q;
      case (det_q)
         DET_IDLE:
            if (toggle_cmd)
               det_d = DET_PRES; // RULE_20
            else if (pres_ev && !(tol_on && !tol_sb_q))
               det_d = DET_PRES; // RULE_18
            else if (sb_ev && !(tol_on && tol_sb_q))
               det_d = DET_EXIT; // RULE_17
         DET_PRES:
            if (toggle_cmd || sb_ev)
               det_d = DET_IDLE; // RULE_18 RULE_20
         DET_EXIT:
            if (toggle_cmd)
               det_d = DET_PRES; // RULE_20
            else if (pres_ev)
               det_d = DET_IDLE; // RULE_17
         default: det_d = DET_IDLE;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         det_q <= DET_IDLE; // RULE_16 RULE_23
         tol_cnt_q <= 5'd0;
         tol_sb_q <= 1'b0;
      end
      else
      begin
         det_q <= det_d;
         // the window masks repeat detections of the sensor that closed tracking
         if (det_q == DET_PRES && det_d == DET_IDLE && !toggle_cmd)
         begin
            tol_cnt_q <= WINDOW_S;
            tol_sb_q <= 1'b1;
         end
         else if (det_q == DET_EXIT && det_d == DET_IDLE)
         begin
            tol_cnt_q <= WINDOW_S;
            tol_sb_q <= 1'b0;
         end
         else if (tick_q && tol_on)
            tol_cnt_q <= tol_cnt_q - 5'd1;
      end
   end

   // incursion stands for the full window, restarted by a new crossing
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         inc_cnt_q <= 5'd0;
         inc_q <= 1'b0;
      end
      else if (inc_set)
      begin
         inc_cnt_q <= WINDOW_S; // RULE_19
         inc_q <= 1'b1;
      end
      else if (tick_q && inc_cnt_q != 5'd0)
      begin
         inc_cnt_q <= inc_cnt_q - 5'd1;
         inc_q <= inc_cnt_q != 5'd1;
      end
   end

   assign reg_rdata = rdata_q;
   assign seg_cmd = seg_cmd_q;
   assign relight = relight_q;
   assign lead_off = lead_off_q;
   assign incursion = inc_q;

   // =====================================================================
   // assertions
   wire agree_any0 = |(~faulty[7:0] & ~(mod_lamp_on[7:0] ^ {8{seg_cmd_q[0]}}));
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_cmd_readback: assert property (wr_seg_cmd ##1 !wr_seg_cmd // RULE_01
      ##1 reg_rd && reg_addr == OFS_SEG_CMD |=> reg_rdata[1:0] == $past(reg_wdata[1:0], 3))
      else $error("segment command readback wrong");
   a_seg_pwr_off: assert property (circ_pwr_off[0] |=> !seg_state_q[0]) // RULE_05
      else $error("segment on while circuit power off");
   a_first_policy: assert property (policy == POL_FIRST && !circ_pwr_off[0] // RULE_04
      && agree_any0 |=> seg_state_q[0] == $past(seg_cmd_q[0]))
      else $error("first-module policy did not update state");
   a_sens_forced: assert property (circ_pwr_off[0] |=> sens_state_q == 4'h0) // RULE_06
      else $error("sensor detect while power off");
   a_sens_err_hold: assert property (circ_pwr_off[0] |=> sens_err_q == $past(sens_err_q)) // RULE_07
      else $error("sensor error changed during power loss");
   a_err_hold: assert property (circ_pwr_off[0] |=> lamp_err_q[7:0] == $past(lamp_err_q[7:0]) // RULE_10
      && mod_err_q[7:0] == $past(mod_err_q[7:0]))
      else $error("lamp or module error changed during power loss");
   a_lamp_off: assert property (circ_pwr_off[0] // RULE_09
      |=> (lamp_state_q[7:0] & ~$past(faulty[7:0])) == 8'h00)
      else $error("healthy lamp on during power loss");
   a_toggle_pres: assert property (toggle_cmd && det_q != DET_PRES |=> det_q == DET_PRES) // RULE_20
      else $error("toggle did not set presence");
   a_incursion: assert property (inc_set |=> inc_q && det_q == DET_IDLE) // RULE_19
      else $error("incursion not raised on crossing");
   a_inc_gate: assert property ($rose(inc_q) |-> $past(stopbar_on)) // RULE_22
      else $error("incursion raised with stopbar off");
   a_exit_entry: assert property (det_q == DET_IDLE && !toggle_cmd && !pres_ev // RULE_17
      && sb_ev && !tol_on |=> det_q == DET_EXIT)
      else $error("stopbar detect from idle did not give exit");

   c_incursion: cover property (inc_set ##1 inc_q);
   c_exit_idle: cover property (det_q == DET_EXIT ##[1:50] det_q == DET_IDLE);
   c_pwr_loss: cover property (seg_state_q[0] ##1 circ_pwr_off[0] ##1 !seg_state_q[0]);
endmodule : seg_status

// *** bench/field_model.sv ***
`timescale 1ns/1ns
// ==========================================================
// field side: lamp monitor modules and sensors
module field_model (
   input wire logic core_clk,
   input wire logic [1:0] seg_cmd,
   input wire logic [15:0] hold,
   input wire logic [3:0] det_req,
   output logic [15:0] mod_lamp_on,
   output logic [3:0] sensor_detect
);
   logic [1:0] hist_q [4] = '{default: 2'h0};
   logic [15:0] lamp_q = 16'h0000;

   // modules answer two to five cycles after seg_cmd so prompt and slow reporters mix;
   // a held module keeps its stale report, as a stuck unit would
   always @(posedge core_clk)
   begin
      hist_q[0] <= seg_cmd;
      for (int k = 1; k < 4; k++)
         hist_q[k] <= hist_q[k-1];
      for (int i = 0; i < 16; i++)
         if (!hold[i])
            lamp_q[i] <= hist_q[i % 4][i / 8];
   end

   // lamps only ever follow the segment command; sensors show the bench's traffic
   assign mod_lamp_on = lamp_q;
   assign sensor_detect = det_req;
endmodule : field_model

// *** bench/seg_status_tb.sv ***
`timescale 1ns/1ns
// ==========================================================
// bench for the segment status and presence logic
module seg_status_tb;
   import seg_status_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic chk_rd = 1'b0;
   logic chk_seen = 1'b0;
   logic [15:0] reg_rdata;
   logic [1:0] circ_pwr_off = 2'h0;
   logic [15:0] mod_lamp_on;
   logic [15:0] mod_lamp_fault = 16'h0000;
   logic [15:0] mod_fail = 16'h0000;
   logic [15:0] hold = 16'h0000;
   logic [3:0] det_req = 4'h0;
   logic [3:0] sensor_detect;
   logic [3:0] sensor_fail = 4'h0;
   logic stopbar_on = 1'b0;
   logic [1:0] seg_cmd;
   logic relight;
   logic [2:0] lead_off;
   logic incursion;
   int err_count = 0;
   int n_compared = 0;
   int cyc = 0;
   int inc_len = 0;
   int relights = 0;
   int n = 0;
   logic [31:0] r;
   logic [31:0] seed = 32'h0000_0012;
   logic [15:0] exp_q [$];
   string name_q [$];

   // ==========================================================
   // design, field and clock
   seg_status #(.TICK_CYCLES(10)) seg_status_i (.core_clk(core_clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .circ_pwr_off(circ_pwr_off), .mod_lamp_on(mod_lamp_on),
      .mod_lamp_fault(mod_lamp_fault), .mod_fail(mod_fail), .sensor_detect(sensor_detect),
      .sensor_fail(sensor_fail), .stopbar_on(stopbar_on), .seg_cmd(seg_cmd),
      .relight(relight), .lead_off(lead_off), .incursion(incursion));
   field_model field_model_i (.core_clk(core_clk), .seg_cmd(seg_cmd), .hold(hold),
      .det_req(det_req), .mod_lamp_on(mod_lamp_on), .sensor_detect(sensor_detect));

   initial
   begin
      forever #5 core_clk = ~core_clk;
   end

   // ==========================================================
   // helpers
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask : chk

   task end_of_test();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_of_test

   task tdone(input string nm);
      $display("test %s finished", nm);
   endtask : tdone

   // one strobe cycle; the following call always waits a fresh edge
   task bus(input logic w, input logic [3:0] a, input logic [15:0] d, input logic ck);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      chk_rd <= ck;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
   endtask : bus

   task wr(input logic [3:0] a, input logic [15:0] d);
      bus(1'b1, a, d, 1'b0);
   endtask : wr

   task rd(input logic [3:0] a, input logic [15:0] e);
      name_q.push_back($sformatf("reg_%0d", a));
      exp_q.push_back(e);
      bus(1'b0, a, 16'h0000, 1'b1);
   endtask : rd

   // unchecked reads until the word shows up, then one checked read
   task poll(input logic [3:0] a, input logic [15:0] e);
      for (int i = 0; i < 400; i++)
      begin
         bus(1'b0, a, 16'h0000, 1'b0);
         #1;
         if (reg_rdata === e)
            break;
      end
      rd(a, e);
   endtask : poll

   task sense(input int k);
      @(posedge core_clk);
      det_req <= 4'(1 << k);
      repeat (3) @(posedge core_clk);
      det_req <= 4'h0;
      repeat (3) @(posedge core_clk);
   endtask : sense

   task wait_lead(input logic [2:0] v, input int lim);
      for (int i = 0; i < lim && lead_off !== v; i++)
      begin
         @(posedge core_clk);
         #1;
      end
      chk("lead_off", {13'h0, v}, {13'h0, lead_off});
   endtask : wait_lead

   task pol_test(input logic [1:0] pol, input logic [15:0] h0, input logic [15:0] h1,
      input logic [15:0] flt);
      wr(OFS_CONFIG, CFG_RESET | {14'h0, pol});
      hold <= h0;
      wr(OFS_SEG_CMD, 16'h0001);
      repeat (20) @(posedge core_clk);
      rd(OFS_SEG_STATE, 16'h0000);
      hold <= h1;
      mod_lamp_fault <= flt;
      poll(OFS_SEG_STATE, 16'h0001);
      hold <= 16'h0000;
      mod_lamp_fault <= 16'h0000;
      wr(OFS_SEG_CMD, 16'h0000);
      poll(OFS_SEG_STATE, 16'h0000);
      tdone("policy");
   endtask : pol_test

   // ==========================================================
   // read results matched against the oldest note; watchdog
   always @(posedge core_clk)
   begin
      if (chk_seen)
         chk(name_q.pop_front(), exp_q.pop_front(), reg_rdata);
      chk_seen <= reg_rd & chk_rd;
      inc_len <= inc_len + int'(incursion === 1'b1);
      relights <= relights + int'(relight === 1'b1);
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         err_count++;
         end_of_test();
      end
   end

   // ==========================================================
   // main sequence
   initial
   begin
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(OFS_CONFIG, CFG_RESET);
      rd(OFS_SEG_CMD, 16'h0000);
      rd(OFS_SB_STATUS, 16'h0100);
      wr(4'h9, 16'hffff);
      rd(4'h9, 16'h0000);
      wr(OFS_SEG_STATE, 16'h0003);
      rd(OFS_SEG_STATE, 16'h0000);
      tdone("reset");
      for (int i = 0; i < 6; i++)
      begin
         r = xs();
         wr(OFS_SEG_CMD, r[15:0]);
         rd(OFS_SEG_CMD, {14'h0, r[1:0]});
         chk("seg_cmd", {14'h0, r[1:0]}, {14'h0, seg_cmd});
      end
      wr(OFS_SEG_CMD, 16'h0000);
      poll(OFS_SEG_STATE, 16'h0000);
      pol_test(POL_TRUE, 16'h0008, 16'h0008, 16'h0008);
      pol_test(POL_PCT, 16'h001f, 16'h000f, 16'h0000);
      pol_test(POL_FIRST, 16'h00ff, 16'h00fe, 16'h0000);
      // fault bits, separate then combined
      wr(OFS_CONFIG, CFG_RESET);
      mod_lamp_fault <= 16'h0002;
      mod_fail <= 16'h0004;
      sensor_fail <= 4'h2;
      det_req <= 4'h4;
      wr(OFS_SEG_CMD, 16'h0001);
      poll(OFS_LAMP_STATE, 16'h00ff);
      rd(OFS_LAMP_ERR, 16'h0002);
      rd(OFS_MOD_ERR, 16'h0004);
      rd(OFS_SENSOR, 16'h0024);
      wr(OFS_CONFIG, CFG_RESET | 16'h0004);
      rd(OFS_LAMP_ERR, 16'h0006);
      rd(OFS_MOD_ERR, 16'h0000);
      wr(OFS_CONFIG, CFG_RESET);
      poll(OFS_SEG_STATE, 16'h0001);
      tdone("errors");
      // circuit 0 loses power, then the field clears its faults
      circ_pwr_off <= 2'h1;
      repeat (5) @(posedge core_clk);
      mod_lamp_fault <= 16'h0000;
      mod_fail <= 16'h0000;
      sensor_fail <= 4'h0;
      repeat (5) @(posedge core_clk);
      rd(OFS_SEG_STATE, 16'h0000);
      rd(OFS_LAMP_STATE, 16'h0006);
      rd(OFS_LAMP_ERR, 16'h0002);
      rd(OFS_MOD_ERR, 16'h0004);
      rd(OFS_SENSOR, 16'h0020);
      circ_pwr_off <= 2'h0;
      det_req <= 4'h0;
      repeat (5) @(posedge core_clk);
      rd(OFS_LAMP_ERR, 16'h0000);
      rd(OFS_SENSOR, 16'h0000);
      wr(OFS_SEG_CMD, 16'h0000);
      tdone("power");
      // presence tracking with the stopbar lit
      stopbar_on <= 1'b1;
      sense(0);
      poll(OFS_SB_STATUS, 16'h0200);
      sense(1);
      poll(OFS_SB_STATUS, 16'h0900);
      chk("incursion", 16'h0001, {15'h0, incursion});
      sense(1);
      rd(OFS_SB_STATUS, 16'h0900);
      poll(OFS_SB_STATUS, 16'h0100);
      chk("inc_len", 16'h0001, 16'(inc_len >= 285 && inc_len <= 315));
      repeat (40) @(posedge core_clk);
      sense(1);
      poll(OFS_SB_STATUS, 16'h0400);
      sense(0);
      poll(OFS_SB_STATUS, 16'h0100);
      sense(0);
      rd(OFS_SB_STATUS, 16'h0100);
      repeat (320) @(posedge core_clk);
      // crossing after the stopbar went dark
      stopbar_on <= 1'b0;
      sense(0);
      poll(OFS_SB_STATUS, 16'h0200);
      sense(1);
      poll(OFS_SB_STATUS, 16'h0100);
      chk("inc_len", 16'h0001, 16'(inc_len >= 285 && inc_len <= 315));
      tdone("presence");
      wr(OFS_SB_CMD, 16'hffff);
      poll(OFS_SB_STATUS, 16'h0200);
      rd(OFS_SB_CMD, 16'h0100);
      wr(OFS_SB_CMD, 16'h0100);
      repeat (5) @(posedge core_clk);
      rd(OFS_SB_STATUS, 16'h0200);
      wr(OFS_SB_CMD, 16'h0000);
      wr(OFS_SB_CMD, 16'h0100);
      poll(OFS_SB_STATUS, 16'h0100);
      wr(OFS_SB_CMD, 16'h0000);
      wr(OFS_CONFIG, CFG_RESET & 16'hfff7);
      sense(0);
      rd(OFS_SB_STATUS, 16'h0100);
      tdone("toggle");
      // fallback timers stand in for absent sensors
      wr(OFS_CONFIG, CFG_RESET & 16'hff8f);
      repeat (320) @(posedge core_clk);
      stopbar_on <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk("lead_off", 16'h0000, {13'h0, lead_off});
      stopbar_on <= 1'b0;
      n = relights;
      repeat (85) @(posedge core_clk);
      chk("lead_off", 16'h0000, {13'h0, lead_off});
      wait_lead(3'h1, 40);
      wait_lead(3'h7, 250);
      chk("relight", 16'h0001, 16'(relights - n));
      // present sensors drive each stage
      wr(OFS_CONFIG, CFG_RESET);
      stopbar_on <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk("lead_off", 16'h0000, {13'h0, lead_off});
      n = relights;
      for (int k = 1; k < 4; k++)
      begin
         sense(k);
         chk("lead_off", 16'(7 >> (3 - k)), {13'h0, lead_off});
      end
      chk("relight", 16'h0001, 16'(relights - n));
      tdone("lead");
      end_of_test();
   end
endmodule : seg_status_tb
